//--- hw/rpfc_params.svh
`ifndef RPFC_PARAMS_SVH
`define RPFC_PARAMS_SVH
// Reference clock rate of the block in hertz.
`define SYS_CLK_HZ 125000000
// Chain clock rate during the period-average phase, in hertz.
`define PA_CLK_HZ 5000000
// Chain clock rate during the frequency-generation phase, in hertz.
`define FG_CLK_HZ 1667000
// Cycles of the system clock between chain ticks, derived from the rates.
`define PA_DIV (`SYS_CLK_HZ / `PA_CLK_HZ)
`define FG_DIV (`SYS_CLK_HZ / `FG_CLK_HZ)
// Width of the tick divider counter.
`define DIV_W 8
// Number of decades in the chain.
`define NUM_DECADES 6
// Radix of each decade.
`define DECADE_RADIX 10
// Periods averaged in the lowest averaging range.
`define BASE_PERIODS 2
// Reset value of every decade.
`define DECADE_RESET 4'h0
`endif

//--- hw/rpfc_pkg.sv
package rpfc_pkg;
	// Measurement phase, one-hot.
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_AVERAGE = 4'b0010,
		ST_FREQGEN = 4'b0100,
		ST_HALT = 4'b1000
	} phase_type;
	// One BCD digit.
	typedef logic [3:0] digit_type;
	// Range select, 0 for the lowest averaging range.
	typedef logic [2:0] range_type;
endpackage : rpfc_pkg

//--- hw/decade_if.sv
`timescale 1ns/1ps
// Carries chain control and state between the top and the decade chain.
interface decade_if;
	// Advance the first decade by one.
	logic tick;
	// Clear every decade.
	logic clear;
	// Decade contents, least significant first.
	logic [23:0] digits;
	// Sticky flag, set by a carry out of the top decade.
	logic overflow;
	modport ctrl (output tick, output clear, input digits, input overflow);
	modport chain (input tick, input clear, output digits, output overflow);
endinterface : decade_if

//--- hw/decade_chain.sv
`timescale 1ns/1ps
`include "rpfc_params.svh"
// Six cascaded BCD decades, each dividing its input by ten.
module decade_chain (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Chain link.
	decade_if.chain link
);
	import rpfc_pkg::*;
	// Carry into each decade; index 0 is the chain input.
	logic [`NUM_DECADES:0] carry;
	// Registered overflow flag.
	logic ovf;
	assign carry[0] = link.tick;
	assign link.overflow = ovf;
	genvar g;
	generate
		for (g = 0; g < `NUM_DECADES; g = g + 1) begin : gen_dec
			digit_type cnt;
			// RULE4 - divide by ten
			assign carry[g + 1] = carry[g] && (cnt == 4'h9);
			// Each decade wraps at nine and passes a carry upward.
			always_ff @(posedge sys_clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					cnt <= `DECADE_RESET;
				end else if (link.clear) begin
					// RULE12 - clear all decades
					cnt <= `DECADE_RESET;
				end else if (carry[g]) begin
					cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
				end
			end
			assign link.digits[g * 4 +: 4] = cnt;
		end
	endgenerate
	// Overflow is sticky until the chain is cleared.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ovf <= 1'b0;
		end else if (carry[`NUM_DECADES]) begin
			ovf <= 1'b1;
		end else if (link.clear) begin
			ovf <= 1'b0;
		end
	end
endmodule : decade_chain

//--- hw/reciprocal_period_freq_counter.sv
// Operation
// RULE1 - Chain holds reciprocal after first average
// RULE2 - Average phase clocks chain at 5 MHz
// RULE3 - Generation phase clocks chain at 1.667 MHz (code divides 125 MHz by 74, about 1.689 MHz)
// RULE4 - Each decade divides by ten, carries
// RULE5 - Chain counts only after scale pulse
// RULE6 - Periods averaged scale tenfold per range
// RULE7 - Scan codes driven when enable low, A/C inverted
// RULE8 - Generation phase follows priority encoder, uninverted
// RULE9 - Gate hold blocks time base pulses
// RULE10 - Stuck max-time line gives one overflowed cycle
// RULE11 - Reset holds cycle output low
// RULE12 - Reset clears decades and phase state
`timescale 1ns/1ps
`include "rpfc_params.svh"
module reciprocal_period_freq_counter (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Measurement input and control lines from the pins.
	input wire logic meas_in_i,
	input wire logic scale_pulse_i,
	input wire logic timebase_pulse_i,
	input wire logic timebase_gate_hold_i,
	input wire logic max_time_i,
	input wire rpfc_pkg::range_type range_i,
	// Address encoder control.
	input wire logic addr_enable_n_i,
	input wire logic [2:0] scan_code_i,
	input wire logic [2:0] prio_code_i,
	// Outputs.
	output logic cycle_o,
	output logic first_phase_line_o,
	output logic second_phase_line_o,
	output logic [2:0] digit_addr_o,
	output logic [23:0] period_freqgen_chain_o,
	output logic overflow_o,
	output logic timebase_out_o
);
	import rpfc_pkg::*;
	// ==========================================================
	// Input synchronisers
	// ==========================================================
	// Three-stage shift registers; stage 0 feeds only stage 1.
	logic [2:0] s_meas, s_scale, s_tb, s_hold, s_max;
	// Debounced levels, updated once stages 1 and 2 agree.
	logic meas, scale, tb, hold, maxt;
	// Previous debounced values for edge detection.
	logic meas_d, scale_d, tb_d;
	// Shift the pin levels through three flops.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_meas <= 3'h0;
			s_scale <= 3'h0;
			s_tb <= 3'h0;
			s_hold <= 3'h0;
			s_max <= 3'h0;
		end else begin
			s_meas <= {s_meas[1:0], meas_in_i};
			s_scale <= {s_scale[1:0], scale_pulse_i};
			s_tb <= {s_tb[1:0], timebase_pulse_i};
			s_hold <= {s_hold[1:0], timebase_gate_hold_i};
			s_max <= {s_max[1:0], max_time_i};
		end
	end
	// Accept a level once the last two stages agree.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meas <= 1'b0;
			scale <= 1'b0;
			tb <= 1'b0;
			hold <= 1'b0;
			maxt <= 1'b0;
		end else begin
			if (s_meas[1] == s_meas[2]) meas <= s_meas[2];
			if (s_scale[1] == s_scale[2]) scale <= s_scale[2];
			if (s_tb[1] == s_tb[2]) tb <= s_tb[2];
			if (s_hold[1] == s_hold[2]) hold <= s_hold[2];
			if (s_max[1] == s_max[2]) maxt <= s_max[2];
		end
	end
	// Remember debounced levels for rising edges.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meas_d <= 1'b0;
			scale_d <= 1'b0;
			tb_d <= 1'b0;
		end else begin
			meas_d <= meas;
			scale_d <= scale;
			tb_d <= tb;
		end
	end
	// Rising edges of the debounced inputs.
	logic meas_rise, scale_rise, tb_rise;
	assign meas_rise = meas && !meas_d;
	assign scale_rise = scale && !scale_d;
	assign tb_rise = tb && !tb_d;
	// ==========================================================
	// Phase control
	// ==========================================================
	phase_type phase, next_phase;
	// Clock-admit flag, set by the scale pulse.
	logic admit;
	// Input periods seen in the current average.
	logic [31:0] periods;
	// Target period count for the selected range.
	logic [31:0] target;
	// Chain tick divider.
	logic [`DIV_W-1:0] div_cnt;
	// Time-base pulses let through the gate.
	logic tb_pass;
	// Set when a generation phase ends with the max-time line still high; holds until reset.
	logic done_once;
	// Decade chain link.
	decade_if link ();
	// Periods to average: two, times ten per range step.
	function automatic logic [31:0] periods_for(input range_type r);
		logic [31:0] p;
		p = 32'(`BASE_PERIODS);
		for (int i = 0; i < 7; i++) begin
			if (i < int'(r)) p = p * 32'(`DECADE_RADIX);
		end
		return p;
	endfunction : periods_for
	// RULE6 - range sets period count
	assign target = periods_for(range_i);
	// RULE9 - gate time base
	assign tb_pass = tb_rise && !hold;
	// Phase sequencing.
	always_comb begin
		next_phase = phase;
		case (phase)
			// A gated time-base pulse starts the cycle, unless halted after a stuck line.
			ST_IDLE: begin
				if (tb_pass && !done_once) next_phase = ST_AVERAGE;
			end
			// RULE1 - average ends with reciprocal held
			ST_AVERAGE: begin
				if (admit && meas_rise && (periods + 32'h1 >= target)) next_phase = ST_FREQGEN;
			end
			// Generation runs until the chain overflows or max time expires.
			ST_FREQGEN: begin
				if (link.overflow || !maxt) next_phase = ST_IDLE;
			end
			ST_HALT: next_phase = ST_HALT;
			default: next_phase = ST_IDLE;
		endcase
	end
	// RULE12 - reset clears phase
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) phase <= ST_IDLE;
		else phase <= next_phase;
	end
	// RULE10 - stuck max line single cycle
	// A high max-time line at the end of generation means overflow ended it; hold until reset.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) done_once <= 1'b0;
		else if (phase == ST_FREQGEN && next_phase == ST_IDLE && maxt) done_once <= 1'b1;
	end
	// RULE5 - scale pulse admits clock
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) admit <= 1'b0;
		else if (phase == ST_IDLE) admit <= 1'b0;
		else if (scale_rise) admit <= 1'b1;
	end
	// Count input periods while the average is admitted.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) periods <= 32'h0;
		else if (phase != ST_AVERAGE) periods <= 32'h0;
		else if (admit && meas_rise) periods <= periods + 32'h1;
	end
	// Tick divider: period chosen by phase.
	logic [`DIV_W-1:0] div_max;
	// RULE2 - 5 MHz in average
	// RULE3 - 1.667 MHz required in generation; divide by 74 gives about 1.689 MHz
	assign div_max = (phase == ST_FREQGEN) ? `DIV_W'(`FG_DIV - 1) : `DIV_W'(`PA_DIV - 1);
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) div_cnt <= '0;
		else if (!admit || div_cnt >= div_max) div_cnt <= '0;
		else div_cnt <= div_cnt + `DIV_W'(1);
	end
	// Tick only while admitted in an active phase; the clear is at cycle start.
	assign link.tick = admit && (div_cnt == div_max) && (phase == ST_AVERAGE || phase == ST_FREQGEN);
	assign link.clear = (phase == ST_IDLE) && (next_phase == ST_AVERAGE);
	decade_chain u_chain (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.link(link)
	);
	// ==========================================================
	// Outputs
	// ==========================================================
	// RULE11 - cycle low in reset
	// Registered outputs; digit address follows scan or encoder.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cycle_o <= 1'b0;
			first_phase_line_o <= 1'b0;
			second_phase_line_o <= 1'b0;
			digit_addr_o <= 3'h0;
			period_freqgen_chain_o <= 24'h0;
			overflow_o <= 1'b0;
			timebase_out_o <= 1'b0;
		end else begin
			cycle_o <= 1'b1;
			first_phase_line_o <= (phase == ST_AVERAGE);
			second_phase_line_o <= (phase == ST_FREQGEN);
			period_freqgen_chain_o <= link.digits;
			overflow_o <= link.overflow;
			timebase_out_o <= tb_pass;
			if (phase == ST_FREQGEN) begin
				// RULE8 - encoder, no inversion
				digit_addr_o <= prio_code_i;
			end else if (!addr_enable_n_i) begin
				// RULE7 - scan, invert A and C
				digit_addr_o <= scan_code_i ^ 3'h5;
			end else begin
				digit_addr_o <= 3'h0;
			end
		end
	end
endmodule : reciprocal_period_freq_counter

//--- tb/reciprocal_period_freq_counter_assertions.sv
`timescale 1ns/1ps
// ==========================================
// Pin-level checks of the measuring block.
module reciprocal_period_freq_counter_assertions (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Pin inputs.
	input wire logic meas_in_i,
	input wire logic scale_pulse_i,
	input wire logic timebase_pulse_i,
	input wire logic timebase_gate_hold_i,
	input wire logic max_time_i,
	input wire rpfc_pkg::range_type range_i,
	input wire logic addr_enable_n_i,
	input wire logic [2:0] scan_code_i,
	input wire logic [2:0] prio_code_i,
	// Pin outputs.
	input wire logic cycle_o,
	input wire logic first_phase_line_o,
	input wire logic second_phase_line_o,
	input wire logic [2:0] digit_addr_o,
	input wire logic [23:0] period_freqgen_chain_o,
	input wire logic overflow_o,
	input wire logic timebase_out_o
);
	import rpfc_pkg::*;
	// Cycles since the chain last moved; it saturates so long idle spans stay harmless.
	logic [7:0] gap;
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gap <= 8'h00;
		end else if ($changed(period_freqgen_chain_o)) begin
			gap <= 8'h00;
		end else if (gap != 8'hFF) begin
			gap <= gap + 8'h01;
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	// A chain step well inside a phase; the first step after admission is left out.
	sequence avg_step_s;
		first_phase_line_o && $past(first_phase_line_o, 30) && $changed(period_freqgen_chain_o)
			&& $past(period_freqgen_chain_o) != 24'h000000;
	endsequence
	sequence gen_step_s;
		second_phase_line_o && $past(second_phase_line_o, 80) && $changed(period_freqgen_chain_o);
	endsequence
	reset_clear_a: assert property (
		!$past(rstn_i) |-> period_freqgen_chain_o == 24'h000000 && !first_phase_line_o && !second_phase_line_o)
		else $error("chain or phase not clear after reset");
	cycle_high_a: assert property ($past(rstn_i) |-> cycle_o)
		else $error("cycle line low outside reset");
	avg_rate_a: assert property (avg_step_s |-> gap == 8'd24)
		else $error("average chain step not 25 cycles");
	gen_rate_a: assert property (gen_step_s |-> gap == 8'd73)
		else $error("generation chain step not 74 cycles");
	scan_addr_a: assert property (
		$past(rstn_i) && !second_phase_line_o && !$past(second_phase_line_o)
		|-> digit_addr_o == ($past(addr_enable_n_i) ? 3'h0 : $past(scan_code_i) ^ 3'h5)) else $error("scan address wrong");
	prio_addr_a: assert property (
		second_phase_line_o && $past(second_phase_line_o) |-> digit_addr_o == $past(prio_code_i))
		else $error("priority address wrong");
	gate_hold_a: assert property (timebase_gate_hold_i [*8] |-> !timebase_out_o)
		else $error("time base pulse passed while held");
	gate_pulse_a: assert property (timebase_out_o |=> !timebase_out_o)
		else $error("time base output longer than one cycle");
	bcd_digit_a: assert property (
		period_freqgen_chain_o[3:0] < 4'hA && period_freqgen_chain_o[7:4] < 4'hA && period_freqgen_chain_o[11:8] < 4'hA
		&& period_freqgen_chain_o[15:12] < 4'hA && period_freqgen_chain_o[19:16] < 4'hA
		&& period_freqgen_chain_o[23:20] < 4'hA) else $error("decade above nine");
endmodule : reciprocal_period_freq_counter_assertions
bind reciprocal_period_freq_counter reciprocal_period_freq_counter_assertions reciprocal_period_freq_counter_assertions_inst (
	.sys_clk_i, .rstn_i, .meas_in_i, .scale_pulse_i, .timebase_pulse_i, .timebase_gate_hold_i, .max_time_i,
	.range_i, .addr_enable_n_i, .scan_code_i, .prio_code_i, .cycle_o, .first_phase_line_o, .second_phase_line_o,
	.digit_addr_o, .period_freqgen_chain_o, .overflow_o, .timebase_out_o);

//--- tb/mainframe_model.sv
`timescale 1ns/1ps
// ==========================================
// Mainframe stand-in: input signal, time base start and scale pulse.
module mainframe_model (
	// Clock.
	input wire logic sys_clk_i,
	// Cycle request and input half period in clock cycles.
	input wire logic start_i,
	input wire logic [15:0] half_i,
	// Lines into the counter.
	output logic meas_in_o,
	output logic timebase_pulse_o,
	output logic scale_pulse_o
);
	// Half-period count, signal level and start step; all change on the rising edge by non-blocking assignment.
	// The bench drives start on the falling edge, so sampling it here on the rising edge avoids a race.
	logic [15:0] half_cnt = 16'h0000;
	logic level = 1'b0;
	logic [7:0] step = 8'h00;
	always @(posedge sys_clk_i) begin
		step <= start_i ? 8'h01 : ((step != 8'h00 && step < 8'd60) ? step + 8'h01 : 8'h00);
		// The input rises just before the scale pulse, so that edge is not counted.
		if (step == 8'd28 || half_cnt + 16'h0001 >= half_i) begin
			half_cnt <= 16'h0000;
			level <= (step == 8'd28) ? 1'b1 : !level;
		end else begin
			half_cnt <= half_cnt + 16'h0001;
		end
	end
	assign meas_in_o = level;
	assign timebase_pulse_o = step >= 8'd1 && step <= 8'd8;
	assign scale_pulse_o = step >= 8'd30 && step <= 8'd37;
endmodule : mainframe_model

//--- tb/reciprocal_period_freq_counter_tb_top.sv
`timescale 1ns/1ps
// ==========================================
// Self-checking bench of the measuring block.
module reciprocal_period_freq_counter_tb_top;
	import rpfc_pkg::*;
	logic sys_clk = 1'b0, rstn, meas_in, scale_pulse, tb_pulse, hold, max_time, enable_n, start, cycle, first, second;
	logic overflow, tb_out;
	range_type range;
	logic [2:0] scan, prio, digit_addr;
	logic [23:0] chain;
	logic [15:0] half;
	logic [31:0] c1;
	int mismatches = 0, compares = 0;
	always #4 sys_clk = !sys_clk;
	reciprocal_period_freq_counter reciprocal_period_freq_counter_inst (.sys_clk_i(sys_clk), .rstn_i(rstn),
		.meas_in_i(meas_in), .scale_pulse_i(scale_pulse), .timebase_pulse_i(tb_pulse), .timebase_gate_hold_i(hold),
		.max_time_i(max_time), .range_i(range), .addr_enable_n_i(enable_n), .scan_code_i(scan), .prio_code_i(prio),
		.cycle_o(cycle), .first_phase_line_o(first), .second_phase_line_o(second), .digit_addr_o(digit_addr),
		.period_freqgen_chain_o(chain), .overflow_o(overflow), .timebase_out_o(tb_out));
	mainframe_model mainframe_model_inst (.sys_clk_i(sys_clk), .start_i(start), .half_i(half), .meas_in_o(meas_in),
		.timebase_pulse_o(tb_pulse), .scale_pulse_o(scale_pulse));
	// Compares with a tolerance; an unknown never matches.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
		compares++;
		if ((got + tol - exp) > 2 * tol || $isunknown(got)) begin
			mismatches++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [31:0] bcd(input logic [23:0] v);
		logic [31:0] r;
		r = 0;
		for (int i = 5; i >= 0; i--) r = r * 10 + v[i*4+:4];
		return r;
	endfunction : bcd
	task print_verdict;
		if (mismatches == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	// Watchdog sized well above the longest expected run.
	initial begin
		repeat (40000) @(posedge sys_clk);
		mismatches++;
		print_verdict();
	end
	initial begin
		{rstn, hold, enable_n, start, scan, prio} = '0;
		{max_time, range, half} = {1'b1, 3'h0, 16'd250};
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk) rstn = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(cycle, 1, 0);
		for (int c = 0; c < 16; c++) begin
			@(negedge sys_clk) {enable_n, scan} = c[3:0];
			repeat (2) @(negedge sys_clk);
			chk(digit_addr, c[3] ? 0 : c[2:0] ^ 3'h5, 0);
		end
		{hold, start} = 2'b11;
		@(negedge sys_clk) start = 1'b0;
		repeat (60) @(negedge sys_clk);
		chk(first, 0, 0);
		hold = 1'b0;
		// Ranges 0 to 2 with half periods chosen so each run stays short.
		for (int m = 0; m < 3; m++) begin
			@(negedge sys_clk) {range, start} = {3'(m), 1'b1};
			half = (m == 0) ? 16'd250 : ((m == 1) ? 16'd50 : 16'd10);
			@(negedge sys_clk) start = 1'b0;
			for (int k = 0; k < 40 && first !== 1'b1; k++) @(negedge sys_clk);
			// Long enough that an ungated divider would already have ticked the chain.
			repeat (40) @(negedge sys_clk);
			chk(chain, 0, 0);
			for (int k = 0; k < 5000 && second !== 1'b1; k++) @(negedge sys_clk);
			chk(bcd(chain), 2 * (10 ** m) * 2 * half / 25, 2);
			c1 = bcd(chain);
			prio = 3'(m + 3);
			repeat (740) @(negedge sys_clk);
			chk(bcd(chain) - c1, 10, 1);
			chk(digit_addr, m + 3, 0);
			chk(overflow, 0, 0);
			max_time = 1'b0;
			for (int k = 0; k < 20 && second !== 1'b0; k++) @(negedge sys_clk);
			chk(second, 0, 0);
			max_time = 1'b1;
		end
		start = 1'b1;
		@(negedge sys_clk) start = 1'b0;
		repeat (200) @(negedge sys_clk);
		rstn = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk({cycle, first, second, chain}, 0, 0);
		print_verdict();
	end
endmodule : reciprocal_period_freq_counter_tb_top
